// file: rtl/xdata_pkg.sv
`default_nettype none
package xdata_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50; // Core clock period
	localparam logic [1:0] CLKS_PER_MC = 2'h3; // Four clocks per machine cycle, counted 0..3
	localparam logic [3:0] MIN_MC = 4'h2; // Shortest stretch setting
	localparam logic [3:0] MAX_MC = 4'h9; // Longest stretch setting
	// ----------------------------------------
	// Address map
	// ----------------------------------------
	localparam logic [15:0] ONCHIP_TOP = 16'h03ff; // Last on-chip data address
	localparam int ONCHIP_DEPTH = 1024;
	localparam logic [7:0] DEC_OPCODE = 8'ha5; // Pointer decrement opcode
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// ----------------------------------------
	// Bus sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_STROBE = 3'b010,
		ST_HOLD = 3'b011,
		ST_DONE = 3'b100
	} bus_state_type;
endpackage
`default_nettype wire

// file: rtl/ext_data_memory_interface.sv
//Contract
//- Machine cycle is four clock periods
//- Access length selectable two to nine cycles
//- Enabled SRAM serves lowest 1 KB moves
//- Reset clears SRAM enable; all external
//- Enable bit maps SRAM; never fetched
//- Scratchpad and data SRAM never alias
//- Bus port actively drives both levels
//- Idle low port is open-drain GPIO
//- Upper address driven on second port
//- Write strobe P3.6, read strobe P3.7
//- Wait enabled makes P4.0 input only
//- Second 16-bit data pointer provided
//- Decrement opcode subtracts one from pointer
//- Select bit chooses active pointer
//- Addresses above 1 KB go external
//- Address latch strobe on each external access
`timescale 1ns/1ps
`default_nettype none
module ext_data_memory_interface
	import xdata_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	// Core request side
	input wire logic REQ_I, // One-cycle data-move request
	input wire logic REQ_WRITE_I, // 1 = write
	input wire logic [7:0] REQ_WDATA_I,
	input wire logic EXEC_I, // Opcode execute strobe
	input wire logic [7:0] OPCODE_I,
	input wire logic PTR_WR_I, // Load a pointer byte
	input wire logic [1:0] PTR_SEL_I, // 0 lo0,1 hi0,2 lo1,3 hi1
	input wire logic [7:0] PTR_WDATA_I,
	// Configuration bits
	input wire logic ONCHIP_XRAM_ENABLE_I,
	input wire logic POINTER_SELECT_I,
	input wire logic [3:0] STRETCH_MC_I, // Access length in machine cycles
	input wire logic WAIT_EN_I,
	input wire logic [7:0] GPIO_LOW_I, // Low port data when not a bus
	// Core answer side
	output logic BUSY_O,
	output logic DONE_O,
	output logic [7:0] RDATA_O,
	output logic [15:0] ACTIVE_PTR_O,
	// Low port pins
	input wire logic [7:0] LOWPORT_I,
	output logic [7:0] LOWPORT_O,
	output logic [7:0] LOWPORT_OE_N_O,
	// Upper port pins
	output logic [7:0] HIGHPORT_O,
	output logic [7:0] HIGHPORT_OE_N_O,
	// Strobes
	output logic ALE_O,
	output logic WR_N_O, // Port 3 bit 6
	output logic RD_N_O, // Port 3 bit 7
	// Wait pin
	input wire logic WAIT_N_I,
	output logic WAIT_PIN_OE_N_O
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		bus_state_type st;
		logic [15:0] ptr0; // Original pointer pair
		logic [15:0] ptr1; // Second pointer pair
		logic [1:0] clk_cnt; // Clock within machine cycle
		logic [3:0] mc_cnt; // Machine cycles left
		logic wr; // Latched direction
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic done;
		logic [2:0] wsync; // Wait pin synchroniser
		logic wait_act; // Filtered wait level
		logic hit; // Take-time on-chip decision, immune to later enable changes
	} state_type;

	state_type cur_ff, nxt_ff;
	logic [7:0] sram_mem [0:ONCHIP_DEPTH-1]; // On-chip data SRAM, separate from scratchpad
	logic [7:0] sram_q;
	logic sram_we;
	logic onchip_hit;
	logic [15:0] act_ptr;

	// Clamp the stretch setting into its legal range
	function automatic logic [3:0] clamp_mc(input logic [3:0] v);
		if (v < MIN_MC) begin
			return MIN_MC;
		end else if (v > MAX_MC) begin
			return MAX_MC;
		end
		return v;
	endfunction

	assign act_ptr = POINTER_SELECT_I ? cur_ff.ptr1 : cur_ff.ptr0;
	// Only the moves that use the lowest 1 KB and the enable go inside
	assign onchip_hit = ONCHIP_XRAM_ENABLE_I && (act_ptr <= ONCHIP_TOP);
	assign sram_we = REQ_I && REQ_WRITE_I && onchip_hit && (cur_ff.st == ST_IDLE);

	// ----------------------------------------
	// On-chip SRAM (data-move only; no fetch port)
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I) begin
		if (sram_we) begin
			sram_mem[act_ptr[9:0]] <= REQ_WDATA_I;
		end
		sram_q <= sram_mem[act_ptr[9:0]];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.done = 1'b0;
		nxt_ff.wsync = {cur_ff.wsync[1:0], ~WAIT_N_I};
		// Act only once two later stages agree, filtering glitches
		if (cur_ff.wsync[2] == cur_ff.wsync[1]) begin
			nxt_ff.wait_act = cur_ff.wsync[2];
		end
		// Pointer byte loads
		if (PTR_WR_I) begin
			case (PTR_SEL_I)
				2'h0: nxt_ff.ptr0[7:0] = PTR_WDATA_I;
				2'h1: nxt_ff.ptr0[15:8] = PTR_WDATA_I;
				2'h2: nxt_ff.ptr1[7:0] = PTR_WDATA_I;
				default: nxt_ff.ptr1[15:8] = PTR_WDATA_I;
			endcase
		end else if (EXEC_I && OPCODE_I == DEC_OPCODE) begin
			if (POINTER_SELECT_I) begin
				nxt_ff.ptr1 = cur_ff.ptr1 - 16'h0001;
			end else begin
				nxt_ff.ptr0 = cur_ff.ptr0 - 16'h0001;
			end
		end
		// Clock within machine cycle
		if (cur_ff.st != ST_IDLE) begin
			nxt_ff.clk_cnt = cur_ff.clk_cnt + 2'h1;
		end
		case (cur_ff.st)
			ST_IDLE: begin
				if (REQ_I) begin
					nxt_ff.wr = REQ_WRITE_I;
					nxt_ff.addr = act_ptr;
					nxt_ff.hit = onchip_hit;
					nxt_ff.wdata = REQ_WDATA_I;
					nxt_ff.clk_cnt = 2'h0;
					nxt_ff.mc_cnt = clamp_mc(STRETCH_MC_I);
					// Internal hits finish at once; external ones run the bus
					nxt_ff.st = onchip_hit ? ST_DONE : ST_ADDR;
				end
			end
			ST_ADDR: begin
				// First machine cycle carries address and latch strobe
				if (cur_ff.clk_cnt == CLKS_PER_MC) begin
					nxt_ff.mc_cnt = cur_ff.mc_cnt - 4'h1;
					nxt_ff.st = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (cur_ff.clk_cnt == CLKS_PER_MC) begin
					if (cur_ff.mc_cnt != 4'h1) begin
						nxt_ff.mc_cnt = cur_ff.mc_cnt - 4'h1;
					end else if (!(WAIT_EN_I && cur_ff.wait_act)) begin
						nxt_ff.rdata = LOWPORT_I;
						nxt_ff.st = ST_HOLD;
					end
				end
			end
			ST_HOLD: begin
				nxt_ff.st = ST_DONE;
			end
			default: begin
				nxt_ff.done = 1'b1;
				// External reads keep their bus data even if the enable flips meanwhile
				if (!cur_ff.wr && cur_ff.hit && cur_ff.addr == act_ptr) begin
					nxt_ff.rdata = sram_q;
				end
				nxt_ff.st = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cur_ff <= '{st: ST_IDLE, ptr0: PTR_RST, ptr1: PTR_RST, clk_cnt: 2'h0,
				mc_cnt: 4'h0, wr: 1'b0, addr: PTR_RST, wdata: BYTE_RST,
				rdata: BYTE_RST, done: 1'b0, wsync: 3'h0, wait_act: 1'b0, hit: 1'b0};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic bus_on;
	assign bus_on = (cur_ff.st == ST_ADDR) || (cur_ff.st == ST_STROBE) || (cur_ff.st == ST_HOLD);
	assign BUSY_O = (cur_ff.st != ST_IDLE);
	assign DONE_O = cur_ff.done;
	assign RDATA_O = cur_ff.rdata;
	assign ACTIVE_PTR_O = act_ptr;
	// Low port: address, then write data or released for reads, else open-drain GPIO
	always_comb begin
		if (cur_ff.st == ST_ADDR) begin
			LOWPORT_O = cur_ff.addr[7:0];
			LOWPORT_OE_N_O = 8'h00;
		end else if (bus_on && cur_ff.wr) begin
			LOWPORT_O = cur_ff.wdata;
			LOWPORT_OE_N_O = 8'h00;
		end else if (bus_on) begin
			LOWPORT_O = 8'h00;
			LOWPORT_OE_N_O = 8'hff; // Released for read data
		end else begin
			// Only drive low; a one releases the pin
			LOWPORT_O = 8'h00;
			LOWPORT_OE_N_O = GPIO_LOW_I;
		end
	end
	assign HIGHPORT_O = cur_ff.addr[15:8];
	assign HIGHPORT_OE_N_O = bus_on ? 8'h00 : 8'hff;
	// Latch strobe high in the first half of the address cycle
	assign ALE_O = (cur_ff.st == ST_ADDR) && !cur_ff.clk_cnt[1];
	assign WR_N_O = !((cur_ff.st == ST_STROBE) && cur_ff.wr);
	assign RD_N_O = !((cur_ff.st == ST_STROBE) && !cur_ff.wr);
	assign WAIT_PIN_OE_N_O = 1'b1;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	machine_cycle_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(cur_ff.st == ST_ADDR && cur_ff.clk_cnt == 2'h0) |-> ALE_O [*2] ##1 !ALE_O [*2])
		else $error("latch strobe not two clocks of four");
	ptr_dec_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(EXEC_I && OPCODE_I == DEC_OPCODE && !PTR_WR_I) |=> (ACTIVE_PTR_O == $past(act_ptr) - 16'h0001
		|| POINTER_SELECT_I != $past(POINTER_SELECT_I)))
		else $error("pointer not decremented");
	onchip_quiet_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(REQ_I && !BUSY_O && onchip_hit) |=> (cur_ff.st == ST_DONE && ALE_O == 1'b0))
		else $error("on-chip access used the bus");
	ext_route_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(REQ_I && !BUSY_O && !onchip_hit) |=> ALE_O)
		else $error("external access missing latch strobe");
	strobe_len_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		$fell(RD_N_O) && !WAIT_EN_I |-> !RD_N_O [*4])
		else $error("read strobe shorter than a machine cycle");
	strobe_excl_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!(!RD_N_O && !WR_N_O))
		else $error("both strobes active");
	bus_drive_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!WR_N_O |-> (LOWPORT_OE_N_O == 8'h00 && LOWPORT_O == cur_ff.wdata))
		else $error("write data not driven");
	high_addr_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		ALE_O |-> (HIGHPORT_OE_N_O == 8'h00 && LOWPORT_OE_N_O == 8'h00
		&& LOWPORT_O == cur_ff.addr[7:0] && HIGHPORT_O == cur_ff.addr[15:8]))
		else $error("address not driven");
endmodule // ext_data_memory_interface
`default_nettype wire

// file: tb/ext_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External memory behind an address latch
// ----------------------------------------
module ext_sram_model (
	input wire logic clk_i,
	input wire logic ale_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [7:0] bus_i, // Resolved low port level
	input wire logic [7:0] hi_i,
	input wire logic [7:0] wait_len_i, // Wait cycles per strobe
	output logic [7:0] drv_o,
	output logic wait_n_o
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr = 16'h0000;
	logic [7:0] last = 8'h00; // A released bus shows its inverse
	logic [7:0] cnt = 8'h00;
	logic strb_q = 1'b0;
	assign drv_o = rd_n_i ? ~last : mem[addr];
	assign wait_n_o = (cnt == 8'h00);
	// Latch, store and wait counter move on the clock
	always @(posedge clk_i) begin
		strb_q <= !(rd_n_i && wr_n_i);
		if (ale_i) addr <= {hi_i, bus_i};
		if (!wr_n_i) mem[addr] <= bus_i;
		if (!rd_n_i) last <= mem[addr];
		if (!(rd_n_i && wr_n_i) && !strb_q) cnt <= wait_len_i;
		else if (cnt != 8'h00) cnt <= cnt - 8'h01;
	end
endmodule // ext_sram_model
`default_nettype wire

// file: tb/ext_data_memory_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Random and corner accesses
// ----------------------------------------
module ext_data_memory_interface_tb;
	import xdata_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, rw = 1'b0, ex = 1'b0, pw = 1'b0;
	logic xen = 1'b0, psel = 1'b0, wen = 1'b0;
	logic [1:0] ps = 2'h0;
	logic [3:0] str = 4'h2;
	logic [7:0] wd = 8'h00, opc = 8'h00, pd = 8'h00, gpio = 8'hff, wlen = 8'h00, d;
	logic [15:0] a;
	wire logic busy, done, ale, wr_n, rd_n, wt_n, wt_oe;
	wire logic [7:0] rdata, lo_o, lo_oe, hi_o, hi_oe, drv, lo_w;
	wire logic [15:0] aptr;
	int err_total = 0, num_checks = 0, cyc = 0, n, alec, strc, bad, bsy;
	// Wire level from both drivers of the low port
	assign lo_w = (lo_o & ~lo_oe) | (drv & lo_oe);
	ext_data_memory_interface u_dut (.REF_CLK_I(clk), .RESETN_I(rst_n), .REQ_I(req),
		.REQ_WRITE_I(rw), .REQ_WDATA_I(wd), .EXEC_I(ex), .OPCODE_I(opc), .PTR_WR_I(pw),
		.PTR_SEL_I(ps), .PTR_WDATA_I(pd), .ONCHIP_XRAM_ENABLE_I(xen), .POINTER_SELECT_I(psel),
		.STRETCH_MC_I(str), .WAIT_EN_I(wen), .GPIO_LOW_I(gpio), .BUSY_O(busy), .DONE_O(done),
		.RDATA_O(rdata), .ACTIVE_PTR_O(aptr), .LOWPORT_I(lo_w), .LOWPORT_O(lo_o),
		.LOWPORT_OE_N_O(lo_oe), .HIGHPORT_O(hi_o), .HIGHPORT_OE_N_O(hi_oe), .ALE_O(ale),
		.WR_N_O(wr_n), .RD_N_O(rd_n), .WAIT_N_I(wt_n), .WAIT_PIN_OE_N_O(wt_oe));
	ext_sram_model u_mem (.clk_i(clk), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.bus_i(lo_w), .hi_i(hi_o), .wait_len_i(wlen), .drv_o(drv), .wait_n_o(wt_n));
	initial forever #25 clk = ~clk;
	// Hang guard, well above the roughly one thousand cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Expected latency of an external access, clamped stretch
	function automatic int lat(input logic [3:0] s);
		return 4 * ((s < MIN_MC) ? MIN_MC : (s > MAX_MC) ? MAX_MC : s) + 2;
	endfunction
	// Load both bytes of pointer 0 (s=0) or pointer 1 (s=2)
	task automatic setp(input logic [1:0] s, input logic [15:0] v);
		for (int b = 0; b < 2; b++) begin
			@(negedge clk);
			ps = {s[1], 1'(b)};
			pd = b ? v[15:8] : v[7:0];
			pw = 1'b1;
		end
		@(negedge clk);
		pw = 1'b0;
	endtask
	task automatic exe(input logic [7:0] op);
		@(negedge clk);
		ex = 1'b1;
		opc = op;
		@(negedge clk);
		ex = 1'b0;
	endtask
	// One access; counts latency, latch strobes, strobe cycles, drive faults
	task automatic xfer(input logic w, input logic [7:0] v);
		@(negedge clk);
		req = 1'b1;
		rw = w;
		wd = v;
		@(negedge clk);
		req = 1'b0;
		n = 0;
		alec = 0;
		strc = 0;
		bad = 0;
		bsy = 0;
		while (done !== 1'b1 && n < 400) begin
			alec += (ale === 1'b1);
			bsy += (busy === 1'b1);
			strc += (rd_n === 1'b0 || wr_n === 1'b0);
			if (ale === 1'b1 && (hi_oe !== 8'h00 || lo_oe !== 8'h00 || hi_o !== aptr[15:8])) bad++;
			if (rd_n === 1'b0 && lo_oe !== 8'hff) bad++;
			@(negedge clk);
			n++;
		end
		@(negedge clk);
	endtask
	initial begin
		void'($urandom(59984));
		gpio = 8'($urandom);
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		chk(16'(lo_oe), 16'(gpio));
		chk(16'(lo_o & ~lo_oe), 16'h0000);
		chk(16'(hi_oe), 16'h00ff);
		chk(16'(busy), 16'h0000);
		// Enable off after reset: low addresses go out on the bus
		setp(2'h0, 16'h03ff);
		xfer(1'b1, 8'h11);
		chk(16'(n), 16'(lat(str)));
		chk({8'h00, u_mem.mem[16'h03ff]}, 16'h0011);
		xen = 1'b1;
		str = 4'h9;
		xfer(1'b1, 8'h22);
		// On-chip accesses answer one cycle after the take, with no bus activity
		chk(16'(n), 16'h0001);
		chk(16'(bsy), 16'h0001);
		chk(16'(alec), 16'h0000);
		xfer(1'b0, 8'h00);
		chk(16'(rdata), 16'h0022);
		chk({8'h00, u_mem.mem[16'h03ff]}, 16'h0011);
		// Every stretch code, out-of-range ones clamp
		for (int s = 0; s < 16; s++) begin
			str = 4'(s);
			a = s ? 16'h0400 + 16'($urandom_range(16'hfbff)) : 16'h0400;
			d = 8'($urandom);
			setp(2'h0, a);
			xfer(1'b1, d);
			chk(16'(n), 16'(lat(str)));
			chk(16'(strc), 16'(lat(str) - 6));
			chk(16'(bsy), 16'(lat(str)));
			xfer(1'b0, 8'h00);
			chk(16'(rdata), 16'(d));
			chk(16'(alec), 16'h0002);
			chk(16'(bad), 16'h0000);
		end
		// Second pointer, select and decrement
		setp(2'h2, 16'h0000);
		psel = 1'b1;
		exe(8'h5a);
		chk(aptr, 16'h0000);
		exe(DEC_OPCODE);
		chk(aptr, 16'hffff);
		psel = 1'b0;
		@(negedge clk);
		chk(aptr, a);
		psel = 1'b1;
		str = 4'h4;
		wlen = 8'h08;
		xfer(1'b1, 8'h3c);
		chk(16'(n), 16'(lat(str)));
		chk({8'h00, u_mem.mem[16'hffff]}, 16'h003c);
		// Wait input stretches the strobe in whole machine cycles
		wen = 1'b1;
		xfer(1'b0, 8'h00);
		chk(16'((n - 2) % 4), 16'h0000);
		chk(16'(n > lat(str)), 16'h0001);
		chk(16'(rdata), 16'h003c);
		chk(16'(wt_oe), 16'h0001);
		gpio = 8'($urandom);
		@(negedge clk);
		chk(16'(lo_oe), 16'(gpio));
		tally_and_finish();
	end
endmodule // ext_data_memory_interface_tb
`default_nettype wire
